// [hdl/lucb_pkg.sv]
// Purpose: Shared constants for the unit configuration register bank.
// Assumes: Eight banks, 8-bit index and data ports.
// Notes: Unit numbers are the host-visible selector values.
package lucb_pkg;
  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HI = 8'h60;
  localparam logic [7:0] IDX_BASE_LO = 8'h61;
  localparam logic [7:0] IDX_BASE2_HI = 8'h62;
  localparam logic [7:0] IDX_BASE2_LO = 8'h63;
  localparam logic [7:0] IDX_IRQ_PRI = 8'h70;
  localparam logic [7:0] IDX_IRQ_SEC = 8'h72;
  localparam logic [7:0] IDX_DMA = 8'h74;
  localparam logic [7:0] IDX_BANK_FIRST = 8'h30;
  // ==========================================================
  // Field positions and reset values
  localparam int ACT_BIT = 0;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_IRQ_FLOPPY = 8'h06;
  localparam logic [7:0] RST_DMA_FLOPPY = 8'h02;
  localparam logic [7:0] RST_DMA_OTHER = 8'h04;
  // ==========================================================
  // Unit numbers as seen in the selector
  localparam logic [7:0] UNIT_FLOPPY = 8'h00;
  localparam logic [7:0] UNIT_PARALLEL = 8'h03;
  localparam logic [7:0] UNIT_SERIAL1 = 8'h04;
  localparam logic [7:0] UNIT_SERIAL2 = 8'h05;
  localparam logic [7:0] UNIT_KEYBOARD = 8'h07;
  localparam logic [7:0] UNIT_GAME = 8'h09;
  localparam logic [7:0] UNIT_RUNTIME = 8'h0A;
  localparam logic [7:0] UNIT_MIDI = 8'h0B;
  // ==========================================================
  // Bank numbers inside the block
  localparam int NUM_BANKS = 8;
  localparam logic [2:0] BANK_FLOPPY = 3'h0;
  localparam logic [2:0] BANK_PARALLEL = 3'h1;
  localparam logic [2:0] BANK_SERIAL1 = 3'h2;
  localparam logic [2:0] BANK_SERIAL2 = 3'h3;
  localparam logic [2:0] BANK_KEYBOARD = 3'h4;
  localparam logic [2:0] BANK_GAME = 3'h5;
  localparam logic [2:0] BANK_RUNTIME = 3'h6;
  localparam logic [2:0] BANK_MIDI = 3'h7;
  // ==========================================================
  // Permitted base ranges
  localparam logic [15:0] BASE_MIN_STD = 16'h0100;
  localparam logic [15:0] BASE_MAX_EIGHT = 16'h0FF8;
  localparam logic [15:0] BASE_MAX_FOUR = 16'h0FFC;
  localparam logic [15:0] BASE_MAX_GAME = 16'h0FFF;
  localparam logic [15:0] BASE_MIN_RUNTIME = 16'h0000;
  localparam logic [15:0] BASE_MAX_RUNTIME = 16'h0F7F;
  localparam logic [15:0] BASE_MAX_MIDI = 16'h0FFE;
  localparam logic [15:0] ALIGN_EIGHT = 16'h0007;
  localparam logic [15:0] ALIGN_FOUR = 16'h0003;
  localparam logic [15:0] ALIGN_TWO = 16'h0001;
  localparam logic [15:0] ALIGN_ONE = 16'h0000;
  localparam logic [15:0] ALIGN_RUNTIME = 16'h007F;
endpackage

// [hdl/lucb_base_check.sv]
// Purpose: Tells whether a unit's programmed base lies in its permitted range.
// Assumes: Pure combinational; the caller registers the result.
// Notes: The keyboard unit is fixed and always reports valid.
`timescale 1ns/100ps
module lucb_base_check (
  input wire logic [2:0] bank,
  input wire logic [15:0] base,
  output logic ok
);
  import lucb_pkg::*;

  // ==========================================================
  // Range and alignment per unit.
  function automatic logic inRange(input logic [15:0] b, input logic [15:0] lo,
                                   input logic [15:0] hi, input logic [15:0] mask);
    inRange = (b >= lo) && (b <= hi) && ((b & mask) == 16'h0000);
  endfunction

  // Selects the window that belongs to this bank.
  always_comb begin
    unique case (bank)
      BANK_FLOPPY, BANK_SERIAL1, BANK_SERIAL2:
        ok = inRange(base, BASE_MIN_STD, BASE_MAX_EIGHT, ALIGN_EIGHT);
      BANK_PARALLEL: ok = inRange(base, BASE_MIN_STD, BASE_MAX_FOUR, ALIGN_FOUR);
      BANK_KEYBOARD: ok = 1'b1;
      BANK_GAME: ok = inRange(base, BASE_MIN_STD, BASE_MAX_GAME, ALIGN_ONE);
      BANK_RUNTIME: ok = inRange(base, BASE_MIN_RUNTIME, BASE_MAX_RUNTIME, ALIGN_RUNTIME);
      BANK_MIDI: ok = inRange(base, BASE_MIN_STD, BASE_MAX_MIDI, ALIGN_TWO);
    endcase
  end
endmodule // lucb_base_check

// [hdl/lucb_bank.sv]
// Purpose: Banked per-unit configuration registers behind an index/data port pair.
// Assumes: Host strobes are synchronous to mclk; cfgState comes from chip-level logic.
// Notes: Hard reset and power-on resets arrive on rst; softRst is the soft reset.
//   The index register lives here; the selector and the state flag live outside.
//   Second base registers exist only for banks marked in SECOND_BASE_BANKS.
//
// What this block does
// - Eight register banks; the unit selector picks the visible one.
// - Host writes an index, then reads or writes through the data port.
// - Bank registers reachable only in configuration state.
// - Activation bit 0 turns unit on; upper bits zero; resets zero.
// - Unit control, vendor control and memory base indices read zero.
// - Indices 0x71, 0x73 and upper reserved ranges read zero, ignore writes.
// - 0x60 holds base bits 15 to 8, 0x61 bits 7 to 0.
// - Units with second base use 0x62 high and 0x63 low.
// - Base registers a unit does not use read zero.
// - Primary interrupt select everywhere; secondary only for keyboard unit.
// - Interrupts default to rising-edge, active-high signalling.
// - Primary interrupt select resets 0x06 for floppy, else zero.
// - DMA select only for floppy and parallel; 0x75 reads zero.
// - DMA select resets 0x02 for floppy, 0x04 for parallel (unit three).
// - Unit is on when activation or power-control bit is set.
// - Activation and power-control bits are linked, always equal.
// - Out-of-range base makes accesses to that unit invalid.
// - Vendor range 0xE0-0xFE and 0xFF reserved.
// - Floppy and serial bases 0x0100 to 0x0FF8, eight-byte aligned.
// - Keyboard unit is fixed, never relocatable.
`timescale 1ns/100ps
module lucb_bank #(
  parameter logic [7:0] SECOND_BASE_BANKS = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic cfgState,
  input wire logic [7:0] unitSel,
  input wire logic indexWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] pwrCtlWr,
  input wire logic [7:0] pwrCtlVal,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  output logic [7:0] unitOn,
  output logic [7:0] unitDecodeOk,
  output logic [127:0] ioBaseFlat,
  output logic [127:0] ioBase2Flat,
  output logic [63:0] irqSelFlat,
  output logic [7:0] irqSel2Keyboard,
  output logic [7:0] dmaSelFloppy,
  output logic [7:0] dmaSelParallel,
  output logic irqEdgeHigh
);
  import lucb_pkg::*;

  // ==========================================================
  // Storage.
  // Index, shared by all banks, and activation state, one bit per bank.
  logic [7:0] index_reg;
  logic [7:0] act_reg;
  // One entry per bank for the base and primary interrupt settings.
  logic [7:0] baseHi_reg [NUM_BANKS];
  logic [7:0] baseLo_reg [NUM_BANKS];
  logic [7:0] base2Hi_reg [NUM_BANKS];
  logic [7:0] base2Lo_reg [NUM_BANKS];
  logic [7:0] irq_reg [NUM_BANKS];
  // Registers owned by a single unit each.
  logic [7:0] irq2_reg;
  logic [7:0] dmaFloppy_reg;
  logic [7:0] dmaParallel_reg;
  // Read path, range-check results and the signalling flag.
  // The range-check results are kept apart from the bank storage on purpose.
  logic [7:0] rdData_reg;
  logic rdValid_reg;
  logic [7:0] decodeOk_reg;
  logic edgeHigh_reg;
  logic [7:0] rdData_next;
  logic [7:0] checkOk;

  // ==========================================================
  // Unit selector to bank number; reserved numbers miss.
  // Bit 3 flags a known unit and bits 2 to 0 give the bank. A reserved number
  // maps to bank zero with the flag clear, so every write enable must also
  // test the flag, or the floppy bank would be hit by mistake.
  function automatic logic [3:0] unitToBank(input logic [7:0] u);
    unique case (u)
      UNIT_FLOPPY: unitToBank = {1'b1, BANK_FLOPPY};
      UNIT_PARALLEL: unitToBank = {1'b1, BANK_PARALLEL};
      UNIT_SERIAL1: unitToBank = {1'b1, BANK_SERIAL1};
      UNIT_SERIAL2: unitToBank = {1'b1, BANK_SERIAL2};
      UNIT_KEYBOARD: unitToBank = {1'b1, BANK_KEYBOARD};
      UNIT_GAME: unitToBank = {1'b1, BANK_GAME};
      UNIT_RUNTIME: unitToBank = {1'b1, BANK_RUNTIME};
      UNIT_MIDI: unitToBank = {1'b1, BANK_MIDI};
      default: unitToBank = 4'h0;
    endcase
  endfunction

  // Reports whether a bank owns the base registers (keyboard does not).
  // The keyboard sits at fixed host addresses, so it has nothing to relocate.
  function automatic logic hasBase(input logic [2:0] b);
    hasBase = (b != BANK_KEYBOARD);
  endfunction

  // ==========================================================
  // Access decode: selector, state and index steer every strobe.
  wire logic [3:0] bankHit = unitToBank(unitSel);
  wire logic unitKnown = bankHit[3];
  wire logic [2:0] bank = bankHit[2:0];
  wire logic bankAccess = cfgState && unitKnown && (index_reg >= IDX_BANK_FIRST);
  wire logic wrOk = dataWr && bankAccess;
  // Bank identity, used by the registers that only one unit owns.
  wire logic isFloppy = (bank == BANK_FLOPPY);
  wire logic isParallel = (bank == BANK_PARALLEL);
  wire logic isKeyboard = (bank == BANK_KEYBOARD);
  wire logic useBase = hasBase(bank);
  wire logic useBase2 = SECOND_BASE_BANKS[bank];
  // One write enable per implemented location. Unused and reserved locations
  // have no enable at all, so a write there simply falls away.
  // Every enable includes wrOk, which carries the state and selector gates.
  wire logic wrAct = wrOk && (index_reg == IDX_ACTIVATE);
  wire logic wrBaseHi = wrOk && useBase && (index_reg == IDX_BASE_HI);
  wire logic wrBaseLo = wrOk && useBase && (index_reg == IDX_BASE_LO);
  wire logic wrBase2Hi = wrOk && useBase2 && (index_reg == IDX_BASE2_HI);
  wire logic wrBase2Lo = wrOk && useBase2 && (index_reg == IDX_BASE2_LO);
  wire logic wrIrq = wrOk && (index_reg == IDX_IRQ_PRI);
  wire logic wrIrq2 = wrOk && isKeyboard && (index_reg == IDX_IRQ_SEC);
  wire logic wrDmaF = wrOk && isFloppy && (index_reg == IDX_DMA);
  wire logic wrDmaP = wrOk && isParallel && (index_reg == IDX_DMA);
  // Both reset sources clear the same registers to the same values.
  wire logic anyRst = rst || softRst;

  // ==========================================================
  // Read mux; every index not named here reads zero.
  // Reads outside configuration state or to a reserved unit also return zero,
  // but they still give a valid strobe, so the host never waits in vain.
  // The zero default at the top keeps the process free of latches.
  always_comb begin
    rdData_next = RST_ZERO;
    if (bankAccess) begin
      unique case (index_reg)
        IDX_ACTIVATE: rdData_next = {7'h00, act_reg[bank]};
        IDX_BASE_HI: rdData_next = useBase ? baseHi_reg[bank] : RST_ZERO;
        IDX_BASE_LO: rdData_next = useBase ? baseLo_reg[bank] : RST_ZERO;
        IDX_BASE2_HI: rdData_next = useBase2 ? base2Hi_reg[bank] : RST_ZERO;
        IDX_BASE2_LO: rdData_next = useBase2 ? base2Lo_reg[bank] : RST_ZERO;
        IDX_IRQ_PRI: rdData_next = irq_reg[bank];
        IDX_IRQ_SEC: rdData_next = isKeyboard ? irq2_reg : RST_ZERO;
        IDX_DMA: begin
          if (isFloppy) begin
            rdData_next = dmaFloppy_reg;
          end else if (isParallel) begin
            rdData_next = dmaParallel_reg;
          end else begin
            rdData_next = RST_ZERO;
          end
        end
        default: rdData_next = RST_ZERO;
      endcase
    end
  end

  // ==========================================================
  // Index register; only taken in configuration state.
  // The index survives data accesses, so a host may read a register and then
  // write it without loading the index again.
  // Outside configuration state the last index is simply kept.
  always_ff @(posedge mclk) begin
    if (anyRst) begin
      index_reg <= RST_ZERO;
    end else if (indexWr && cfgState) begin
      index_reg <= hostWrData;
    end
  end

  // Read answer, one cycle after the read strobe.
  // The data holds until the next read, so a slow host may pick it up late.
  always_ff @(posedge mclk) begin
    if (anyRst) begin
      rdData_reg <= RST_ZERO;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= dataRd;
      if (dataRd) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  // Activation bits double as power-control bits; either write path moves both.
  // A host write wins over a power-control pulse in the same cycle, since
  // the host has just asked for that value explicitly.
  // Keeping one flop per unit makes it impossible for the two bits to differ.
  always_ff @(posedge mclk) begin
    if (anyRst) begin
      act_reg <= RST_ZERO;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (wrAct && (bank == 3'(i))) begin
          act_reg[i] <= hostWrData[ACT_BIT];
        end else if (pwrCtlWr[i]) begin
          act_reg[i] <= pwrCtlVal[i];
        end
      end
    end
  end

  // Base, second base and primary interrupt select of each bank.
  // Only the bank that the selector points at can change.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_BANKS; i++) begin
      if (anyRst) begin
        baseHi_reg[i] <= RST_ZERO;
        baseLo_reg[i] <= RST_ZERO;
        base2Hi_reg[i] <= RST_ZERO;
        base2Lo_reg[i] <= RST_ZERO;
        irq_reg[i] <= (i == int'(BANK_FLOPPY)) ? RST_IRQ_FLOPPY : RST_ZERO;
      end else if (bank == 3'(i)) begin
        if (wrBaseHi) begin
          baseHi_reg[i] <= hostWrData;
        end
        if (wrBaseLo) begin
          baseLo_reg[i] <= hostWrData;
        end
        if (wrBase2Hi) begin
          base2Hi_reg[i] <= hostWrData;
        end
        if (wrBase2Lo) begin
          base2Lo_reg[i] <= hostWrData;
        end
        if (wrIrq) begin
          irq_reg[i] <= hostWrData;
        end
      end
    end
  end

  // Registers that exist for one or two units only.
  // The signalling flag is rewritten every cycle, so no write path can clear it.
  always_ff @(posedge mclk) begin
    if (anyRst) begin
      irq2_reg <= RST_ZERO;
      dmaFloppy_reg <= RST_DMA_FLOPPY;
      dmaParallel_reg <= RST_DMA_OTHER;
      edgeHigh_reg <= 1'b1;
    end else begin
      edgeHigh_reg <= 1'b1;
      if (wrIrq2) begin
        irq2_reg <= hostWrData;
      end
      if (wrDmaF) begin
        dmaFloppy_reg <= hostWrData;
      end
      if (wrDmaP) begin
        dmaParallel_reg <= hostWrData;
      end
    end
  end

  // ==========================================================
  // Range check per bank, registered so the enables come from flops.
  // A base is briefly out of range between its high and low byte writes,
  // so the decode that uses these flags must tolerate that short window.
  // Registering the flags keeps them free of glitches while a byte lands.
  // The keyboard check always passes, as its addresses are fixed.
  genvar g;
  generate
    for (g = 0; g < NUM_BANKS; g++) begin : gCheck
      lucb_base_check uCheck (
        .bank(3'(g)),
        .base({baseHi_reg[g], baseLo_reg[g]}),
        .ok(checkOk[g])
      );
      assign ioBaseFlat[g*16 +: 16] = {baseHi_reg[g], baseLo_reg[g]};
      assign ioBase2Flat[g*16 +: 16] = {base2Hi_reg[g], base2Lo_reg[g]};
      assign irqSelFlat[g*8 +: 8] = irq_reg[g];
    end
  endgenerate

  // Decode is allowed only for units whose base sits in range.
  // An out-of-range bank reports zero, so its I/O decode stays off.
  // The flag lags the base write by one edge.
  always_ff @(posedge mclk) begin
    if (anyRst) begin
      decodeOk_reg <= RST_ZERO;
    end else begin
      decodeOk_reg <= checkOk;
    end
  end

  // ==========================================================
  // Outputs straight from registers.
  // The three flat buses are driven inside the generate loop above.
  // No logic stands between any of these registers and its port.
  assign hostRdData = rdData_reg;
  assign hostRdValid = rdValid_reg;
  assign unitOn = act_reg;
  assign unitDecodeOk = decodeOk_reg;
  assign irqSel2Keyboard = irq2_reg;
  assign dmaSelFloppy = dmaFloppy_reg;
  assign dmaSelParallel = dmaParallel_reg;
  assign irqEdgeHigh = edgeHigh_reg;
endmodule // lucb_bank

// [verif/lucb_bank_props.sv]
// Purpose: Concurrent checks on the ports of the unit configuration bank.
// Assumes: The index register is shadowed here from the host strobes.
// Notes: Bound to the bank from the testbench top.
`timescale 1ns/100ps
module lucb_bank_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic softRst,
  input wire logic cfgState,
  input wire logic [7:0] unitSel,
  input wire logic indexWr,
  input wire logic dataWr,
  input wire logic dataRd,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] pwrCtlWr,
  input wire logic [7:0] pwrCtlVal,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid,
  input wire logic [7:0] unitOn,
  input wire logic [63:0] irqSelFlat,
  input wire logic [7:0] dmaSelFloppy,
  input wire logic [7:0] dmaSelParallel,
  input wire logic irqEdgeHigh
);
  // ==========================================================
  // Index shadow and decode
  logic [7:0] idx_reg;
  wire wrFlop = cfgState && dataWr && unitSel == 8'h00;
  wire rsv = (idx_reg >= 8'h31 && idx_reg <= 8'h5F) || idx_reg == 8'h71 ||
             idx_reg == 8'h73 || idx_reg >= 8'h75;
  // The shadow follows index writes taken in configuration state.
  always_ff @(posedge mclk) begin
    if (rst || softRst) idx_reg <= 8'h00;
    else if (indexWr && cfgState) idx_reg <= hostWrData;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst || softRst);
  // ==========================================================
  // Properties
  chk_valid_one: assert property (1'h1 |=> hostRdValid == $past(dataRd))
    else $error("read answer not one cycle after the read strobe");
  chk_act_follow: assert property (wrFlop && idx_reg == 8'h30 |=>
    unitOn[0] == $past(hostWrData[0])) else $error("activation bit not written");
  chk_cfg_gate: assert property (!cfgState && dataWr && pwrCtlWr == 8'h00 |=>
    $stable(unitOn) && $stable(irqSelFlat)) else $error("write taken outside config");
  chk_reset_vals: assert property ($past(rst || softRst) |-> unitOn == 8'h00 &&
    irqSelFlat == 64'h6 && dmaSelFloppy == 8'h02 && dmaSelParallel == 8'h04)
    else $error("wrong value after reset");
  chk_edge_high: assert property (1'h1 |-> irqEdgeHigh)
    else $error("interrupt signalling not edge high");
  chk_rsv_zero: assert property (dataRd && rsv |=> hostRdData == 8'h00)
    else $error("reserved index read not zero");
  chk_irq_floppy: assert property (wrFlop && idx_reg == 8'h70 |=>
    irqSelFlat[7:0] == $past(hostWrData)) else $error("interrupt select not written");
  chk_dma_floppy: assert property (wrFlop && idx_reg == 8'h74 |=>
    dmaSelFloppy == $past(hostWrData)) else $error("DMA select not written");
  chk_rsv_unit: assert property (dataRd && unitSel == 8'h01 |=> hostRdData == 8'h00)
    else $error("reserved unit read not zero");
  chk_pwr_link: assert property (pwrCtlWr[1] && !(cfgState && dataWr) |=>
    unitOn[1] == $past(pwrCtlVal[1])) else $error("power bit not linked");
endmodule // lucb_bank_props

// [verif/lucb_host_model.sv]
// Purpose: Host side of the index/data configuration port pair.
// Assumes: Strobes move one nanosecond after the rising edge.
// Notes: Write data is inverted once released so stale values never linger.
`timescale 1ns/100ps
module lucb_host_model (
  input wire logic mclk,
  output logic indexWr,
  output logic dataWr,
  output logic dataRd,
  output logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid
);
  int lost = 0;
  // Idle levels from time zero.
  initial begin
    indexWr = 1'h0;
    dataWr = 1'h0;
    dataRd = 1'h0;
    hostWrData = 8'h00;
  end
  // One transfer: index pulse, data pulse, then a bounded wait for the answer.
  task automatic xfer(input logic [7:0] i, input logic [7:0] d, input bit rd,
                      output logic [7:0] q);
    int n;
    @(posedge mclk);
    #1;
    indexWr = 1'h1;
    hostWrData = i;
    @(posedge mclk);
    #1;
    indexWr = 1'h0;
    hostWrData = d;
    dataWr = !rd;
    dataRd = rd;
    @(posedge mclk);
    #1;
    dataWr = 1'h0;
    dataRd = 1'h0;
    hostWrData = ~d;
    n = 0;
    while (rd && hostRdValid !== 1'h1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (rd && hostRdValid !== 1'h1) lost++;
    q = hostRdData;
  endtask
endmodule // lucb_host_model

// [verif/lucb_bank_tb_top.sv]
// Purpose: Self-checking bench for the unit configuration bank.
// Assumes: Bank order and unit numbers as in the shared package.
// Notes: Inputs change one nanosecond after the rising edge.
`timescale 1ns/100ps
module lucb_bank_tb_top;
  import lucb_pkg::*;
  // ==========================================================
  // Signals and tables
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic softRst = 1'h0;
  logic cfgState = 1'h1;
  logic [7:0] unitSel = 8'h00;
  logic [7:0] pwrCtlWr = 8'h00;
  logic [7:0] pwrCtlVal = 8'h00;
  logic indexWr, dataWr, dataRd, hostRdValid, irqEdgeHigh;
  logic [7:0] hostWrData, hostRdData, q, unitOn, unitDecodeOk, irqSel2Keyboard;
  logic [7:0] dmaSelFloppy, dmaSelParallel;
  logic [127:0] ioBaseFlat, ioBase2Flat;
  logic [63:0] irqSelFlat;
  int failures = 0;
  int checksDone = 0;
  logic [7:0] units [8] = '{UNIT_FLOPPY, UNIT_PARALLEL, UNIT_SERIAL1, UNIT_SERIAL2,
                           UNIT_KEYBOARD, UNIT_GAME, UNIT_RUNTIME, UNIT_MIDI};
  logic [7:0] rsvIdx [12] = '{8'h31, 8'h38, 8'h40, 8'h5F, 8'h64, 8'h71, 8'h73, 8'h75,
                             8'h76, 8'hA9, 8'hE0, 8'hFF};
  logic [15:0] bases [4] = '{16'h00F8, 16'h0100, 16'h0FF8, 16'h0FFC};
  // Clock at 50 MHz.
  always #10 mclk = ~mclk;
  lucb_bank u_lucb_bank (.mclk, .rst, .softRst, .cfgState, .unitSel, .indexWr, .dataWr,
    .dataRd, .hostWrData, .pwrCtlWr, .pwrCtlVal, .hostRdData, .hostRdValid, .unitOn,
    .unitDecodeOk, .ioBaseFlat, .ioBase2Flat, .irqSelFlat, .irqSel2Keyboard,
    .dmaSelFloppy, .dmaSelParallel, .irqEdgeHigh);
  lucb_host_model u_lucb_host_model (.mclk, .indexWr, .dataWr, .dataRd, .hostWrData,
    .hostRdData, .hostRdValid);
  // ==========================================================
  // Access and compare tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_lucb_host_model.xfer(i, d, 1'h0, q);
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    u_lucb_host_model.xfer(i, 8'h00, 1'h1, q);
    check($sformatf("index %h", i), {8'h00, q}, {8'h00, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic report_and_stop();
    check("lost answers", 16'(u_lucb_host_model.lost), 16'h0000);
    $display("Checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    tick(8);
    rst = 1'h0;
    for (int b = 0; b < 8; b++) begin
      unitSel = units[b];
      rd(IDX_ACTIVATE, 8'h00);
      rd(IDX_IRQ_PRI, b == 0 ? 8'h06 : 8'h00);
      rd(IDX_DMA, b == 0 ? 8'h02 : (b == 1 ? 8'h04 : 8'h00));
      rd(IDX_IRQ_SEC, 8'h00);
      wr(IDX_IRQ_PRI, 8'h10 + 8'(b));
    end
    check("irq banks", irqSelFlat[15:0], 16'h1110);
    check("irq midi", {8'h00, irqSelFlat[63:56]}, 16'h0017);
    unitSel = UNIT_SERIAL1;
    foreach (rsvIdx[k]) begin
      wr(rsvIdx[k], 8'hFF);
      rd(rsvIdx[k], 8'h00);
    end
    wr(IDX_IRQ_SEC, 8'h33);
    rd(IDX_IRQ_SEC, 8'h00);
    wr(IDX_DMA, 8'h33);
    rd(IDX_DMA, 8'h00);
    wr(IDX_BASE2_HI, 8'h33);
    rd(IDX_BASE2_HI, 8'h00);
    check("second base", ioBase2Flat[47:32], 16'h0000);
    foreach (bases[k]) begin
      wr(IDX_BASE_HI, bases[k][15:8]);
      wr(IDX_BASE_LO, bases[k][7:0]);
      rd(IDX_BASE_HI, bases[k][15:8]);
      check("serial base", ioBaseFlat[47:32], bases[k]);
      check("serial decode", {15'h0, unitDecodeOk[2]}, 16'(k == 1 || k == 2));
    end
    unitSel = UNIT_KEYBOARD;
    wr(IDX_IRQ_SEC, 8'h0C);
    rd(IDX_IRQ_SEC, 8'h0C);
    check("kbd irq2", {8'h00, irqSel2Keyboard}, 16'h000C);
    check("kbd decode", {15'h0, unitDecodeOk[4]}, 16'h0001);
    unitSel = UNIT_FLOPPY;
    wr(IDX_DMA, 8'h03);
    check("floppy dma", {8'h00, dmaSelFloppy}, 16'h0003);
    wr(IDX_ACTIVATE, 8'hFF);
    rd(IDX_ACTIVATE, 8'h01);
    check("floppy on", {8'h00, unitOn}, 16'h0001);
    pwrCtlWr = 8'h01;
    tick(1);
    pwrCtlWr = 8'h00;
    rd(IDX_ACTIVATE, 8'h00);
    pwrCtlVal = 8'h02;
    pwrCtlWr = 8'h02;
    tick(1);
    pwrCtlWr = 8'h00;
    unitSel = UNIT_PARALLEL;
    rd(IDX_ACTIVATE, 8'h01);
    check("unit on", {8'h00, unitOn}, 16'h0002);
    cfgState = 1'h0;
    wr(IDX_ACTIVATE, 8'h00);
    tick(1);
    check("outside config", {8'h00, unitOn}, 16'h0002);
    cfgState = 1'h1;
    unitSel = 8'h01;
    wr(IDX_ACTIVATE, 8'h01);
    rd(IDX_ACTIVATE, 8'h00);
    check("reserved unit", {8'h00, unitOn}, 16'h0002);
    softRst = 1'h1;
    tick(1);
    softRst = 1'h0;
    check("dma after reset", {8'h00, dmaSelFloppy}, 16'h0002);
    check("irq after reset", irqSelFlat[15:0], 16'h0006);
    check("edge high", {15'h0, irqEdgeHigh}, 16'h0001);
    report_and_stop();
  end
endmodule // lucb_bank_tb_top

bind lucb_bank lucb_bank_props u_lucb_bank_props (.mclk, .rst, .softRst, .cfgState, .unitSel,
  .indexWr, .dataWr, .dataRd, .hostWrData, .pwrCtlWr, .pwrCtlVal, .hostRdData, .hostRdValid,
  .unitOn, .irqSelFlat, .dmaSelFloppy, .dmaSelParallel, .irqEdgeHigh);
